// *** pwmh_pkg.sv ***
// Purpose: Shared constants for the five-output PWM / H-bridge block
// Assumes: 32-bit AXI4-Lite data, one aligned word per register
// Notes: Register indices count 32-bit words; 16-bit registers sit in bits 15:0
package pwmh_pkg;
  // ************************************************************
  // Address map
  // ************************************************************
  localparam logic [31:0] BASE_ADDR = 32'hffff0f80;
  localparam int unsigned NUM_IDX = 16;
  localparam logic [3:0] IDX_CTRL = 4'h0;
  localparam logic [3:0] IDX_P0_CMP_A = 4'h1;
  localparam logic [3:0] IDX_P0_PERIOD = 4'h4;
  localparam logic [3:0] IDX_P1_PERIOD = 4'h8;
  localparam logic [3:0] IDX_HOLE = 4'hb;
  localparam logic [3:0] IDX_CH4_PERIOD = 4'hc;
  localparam logic [3:0] IDX_COUNT = 4'hd;
  localparam logic [3:0] IDX_IRQ_CLEAR = 4'he;
  localparam logic [3:0] IDX_STATUS = 4'hf;
  localparam int unsigned PAIR_STRIDE = 4;
  // ************************************************************
  // Control register fields
  // ************************************************************
  localparam int unsigned B_EN = 0;
  localparam int unsigned B_HBRIDGE_SELECT = 1;
  localparam int unsigned B_DIR = 2;
  localparam int unsigned B_HIGH_SIDE_OFF = 4;
  localparam int unsigned B_POINV = 5;
  localparam int unsigned B_CP_LO = 6;
  localparam int unsigned CP_W = 3;
  localparam int unsigned B_ENA = 9;
  localparam int unsigned B_TRIP = 10;
  localparam int unsigned B_INV1 = 11;
  localparam int unsigned B_INV3 = 12;
  localparam int unsigned B_SYNC = 14;
  localparam logic [15:0] CTRL_RESET = 16'h0012;
  localparam logic [15:0] CTRL_WMASK = 16'h5fff;
  localparam logic [15:0] CMP_RESET = 16'h0000;
  // ************************************************************
  // Bus answers
  // ************************************************************
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// *** pwmh_top.sv ***
// Purpose: Five-output PWM with H-bridge steering, AXI4-Lite registers
// Assumes: trip_pin and sync_pin are asynchronous to aclk
// Notes: aclk is the peripheral clock that the prescaler divides
// Function
// R1 - Five outputs, H-bridge or standard; reset leaves H-bridge mode, motor off
// R2 - Standard mode: two pairs plus a fifth output, own period each, own duty per output
// R3 - Outputs change where the 16-bit timer equals a compare value
// R4 - Timer clock is aclk divided by 2 up to 256
// R5 - Prescale field bits 8:6, code n divides by two to the n+1
// R6 - Each pair period comes from its period register
// R7 - High side rises at compare a, falls at compare b
// R8 - Low side rises at period, falls at compare c or high-side fall
// R9 - Fifth output has two compares and its own period
// R10 - Sync enabled: counters reset the edge after a sync falling edge
// R11 - Software writes zero to control bit 13
// R12 - Bit 12 inverts output 3, bit 11 inverts output 1
// R13 - Trip enabled and trip low: clear master enable, raise interrupt
// R14 - In H-bridge mode bit 9 enables outputs; otherwise ignored
// R15 - Control register is 16-bit read/write, resets to 0x0012
// R16 - Any write to the clear register clears the trip interrupt; a trip in the same cycle keeps it set
// R17 - High side off forces outputs 0,2 high and 1,3 low
// R18 - Control bit 0 enables or disables all outputs; with high side off set, outputs 0 and 2 still stay high
// R19 - Control bit 1 selects H-bridge mode, clear is standard
// R20 - Timer restarts from zero after reaching the period
// R21 - Trip and sync pins pass two flip-flops before use
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/10ps
module pwmh_top #(
  parameter int unsigned CNT_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic trip_pin,
  input wire logic sync_pin,
  output logic [4:0] pwm_out,
  output logic trip_irq
);
  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic hit(input logic [31:0] a);
    hit = (a[31:6] == pwmh_pkg::BASE_ADDR[31:6]) &&
          (a[5:2] != pwmh_pkg::IDX_HOLE);
  endfunction

  function automatic logic [7:0] pre_last(input logic [2:0] cp);
    pre_last = 8'((9'h002 << cp) - 9'h001);
  endfunction

  logic [15:0] cfg [0:12];
  logic [15:0] ctrl;
  logic [CNT_W-1:0] cnt [0:2];
  logic [2:0] hs;
  logic [2:0] ls;
  logic [7:0] pre_cnt;
  logic tick;
  logic trip_s1;
  logic trip_s2;
  logic sync_s1;
  logic sync_s2;
  logic sync_s3;
  logic sync_fire;
  logic trip_hit;
  logic aw_held;
  logic w_held;
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_wr;
  logic [3:0] w_idx;
  logic [4:0] next_out;

  assign ctrl = cfg[pwmh_pkg::IDX_CTRL];
  assign w_idx = aw_addr[5:2];
  assign do_wr = aw_held && w_held && !s_axi_bvalid;
  assign trip_hit = ctrl[pwmh_pkg::B_TRIP] && !trip_s2; // R13

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trip_s1 <= 1'b1;
      trip_s2 <= 1'b1;
      sync_s1 <= 1'b1;
      sync_s2 <= 1'b1;
      sync_s3 <= 1'b1;
    end else begin
      trip_s1 <= trip_pin; // R21
      trip_s2 <= trip_s1; // R21
      sync_s1 <= sync_pin; // R21
      sync_s2 <= sync_s1; // R21
      sync_s3 <= sync_s2;
    end
  end

  // Edge found one cycle, counters cleared at the following edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_fire <= 1'b0;
    end else begin
      sync_fire <= ctrl[pwmh_pkg::B_SYNC] && sync_s3 && !sync_s2; // R10
    end
  end

  // ************************************************************
  // Register file
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg[pwmh_pkg::IDX_CTRL] <= pwmh_pkg::CTRL_RESET; // R1 R15
      for (int i = 1; i < 13; i++) begin
        cfg[i] <= pwmh_pkg::CMP_RESET;
      end
    end else begin
      if (do_wr && hit(aw_addr) && (w_idx < 4'hd)) begin
        for (int b = 0; b < 2; b++) begin
          if (w_strb[b]) begin
            cfg[w_idx][b*8 +: 8] <= w_data[b*8 +: 8];
          end
        end
        if (w_idx == pwmh_pkg::IDX_CTRL) begin
          // Reserved bit 13 and bit 15 never store
          for (int b = 0; b < 2; b++) begin
            if (w_strb[b]) begin
              cfg[0][b*8 +: 8] <= w_data[b*8 +: 8] &
                pwmh_pkg::CTRL_WMASK[b*8 +: 8]; // R11 R15
            end
          end
        end
      end
      // Trip beats a software write in the same cycle
      if (trip_hit) begin
        cfg[pwmh_pkg::IDX_CTRL][pwmh_pkg::B_EN] <= 1'b0; // R13
      end
    end
  end

  // Sticky trip flag; a new trip wins over a clear write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trip_irq <= 1'b0;
    end else if (trip_hit) begin
      trip_irq <= 1'b1; // R13
    end else if (do_wr && hit(aw_addr) &&
                 (w_idx == pwmh_pkg::IDX_IRQ_CLEAR)) begin
      trip_irq <= 1'b0; // R16
    end
  end

  // ************************************************************
  // Prescaler
  // ************************************************************
  assign tick = (pre_cnt == pre_last(ctrl[pwmh_pkg::B_CP_LO +:
                 pwmh_pkg::CP_W])); // R4 R5

  always_ff @(posedge aclk) begin
    if (!aresetn || sync_fire) begin
      pre_cnt <= 8'h00;
    end else if (tick || (pre_cnt > pre_last(ctrl[pwmh_pkg::B_CP_LO +:
                 pwmh_pkg::CP_W]))) begin
      // Shrinking the divisor mid-count must not strand the counter
      pre_cnt <= 8'h00;
    end else begin
      pre_cnt <= pre_cnt + 8'h01;
    end
  end

  // ************************************************************
  // Timers and pair waveforms
  // ************************************************************
  for (genvar p = 0; p < 3; p++) begin : g_pair
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [15:0] cmp_c;
    logic [15:0] len;
    logic next_hs;
    logic next_ls;
    assign cmp_a = cfg[1 + p*pwmh_pkg::PAIR_STRIDE];
    assign cmp_b = cfg[2 + p*pwmh_pkg::PAIR_STRIDE];
    // Fifth output has no third compare
    assign cmp_c = (p == 2) ? 16'h0000 :
                   cfg[3 + p*pwmh_pkg::PAIR_STRIDE]; // R9
    assign len = cfg[4 + p*pwmh_pkg::PAIR_STRIDE]; // R6
    always_comb begin
      next_hs = hs[p];
      if (cnt[p] == CNT_W'(cmp_a)) begin
        next_hs = 1'b1; // R7 R3
      end else if (cnt[p] == CNT_W'(cmp_b)) begin
        next_hs = 1'b0; // R7
      end
      next_ls = ls[p];
      if ((cnt[p] == CNT_W'(cmp_c)) || (hs[p] && !next_hs)) begin
        next_ls = 1'b0; // R8
      end else if (cnt[p] == CNT_W'(len)) begin
        next_ls = 1'b1; // R8
      end
    end
    always_ff @(posedge aclk) begin
      if (!aresetn || sync_fire) begin
        cnt[p] <= '0; // R10
      end else if (tick) begin
        if (cnt[p] >= CNT_W'(len)) begin
          cnt[p] <= '0; // R20
        end else begin
          cnt[p] <= cnt[p] + CNT_W'(1);
        end
      end
    end
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        hs[p] <= 1'b0;
        ls[p] <= 1'b0;
      end else if (tick) begin
        hs[p] <= next_hs;
        ls[p] <= (p == 2) ? 1'b0 : next_ls;
      end
    end
  end

  // ************************************************************
  // Output steering
  // ************************************************************
  always_comb begin
    next_out = {hs[2], ls[1], hs[1], ls[0], hs[0]}; // R2
    if (ctrl[pwmh_pkg::B_HBRIDGE_SELECT]) begin // R19
      if (!ctrl[pwmh_pkg::B_ENA]) begin
        next_out[3:0] = 4'hf; // R14
      end else begin
        unique case ({ctrl[pwmh_pkg::B_POINV], ctrl[pwmh_pkg::B_DIR]})
          2'b00: next_out[3:0] = {ls[0], hs[0], 2'b00};
          2'b01: next_out[3:0] = {2'b00, ls[0], hs[0]};
          2'b10: next_out[3:0] = {2'b11, ls[0], hs[0]};
          2'b11: next_out[3:0] = {ls[0], hs[0], 2'b11};
        endcase
      end
    end
    next_out[1] = next_out[1] ^ ctrl[pwmh_pkg::B_INV1]; // R12
    next_out[3] = next_out[3] ^ ctrl[pwmh_pkg::B_INV3]; // R12
    if (!ctrl[pwmh_pkg::B_EN]) begin
      next_out = 5'h00; // R18
    end
    // Safe state overrides everything so the bridge stays off
    if (ctrl[pwmh_pkg::B_HIGH_SIDE_OFF]) begin
      next_out[3:0] = 4'h5; // R17 R1
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_out <= 5'h05;
    end else begin
      pwm_out <= next_out;
    end
  end

  // ************************************************************
  // AXI4-Lite write channel
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 32'h00000000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pwmh_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= hit(aw_addr) ? pwmh_pkg::RESP_OKAY :
                       pwmh_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ************************************************************
  // AXI4-Lite read channel
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= pwmh_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= hit(s_axi_araddr) ? pwmh_pkg::RESP_OKAY :
                     pwmh_pkg::RESP_SLVERR;
      s_axi_rdata <= 32'h00000000;
      if (hit(s_axi_araddr)) begin
        unique case (s_axi_araddr[5:2])
          pwmh_pkg::IDX_COUNT: s_axi_rdata <= 32'(cnt[0]);
          pwmh_pkg::IDX_IRQ_CLEAR: s_axi_rdata <= 32'h00000000;
          pwmh_pkg::IDX_STATUS: s_axi_rdata <= {30'h0, trip_s2, trip_irq};
          default: s_axi_rdata <= {16'h0000, cfg[s_axi_araddr[5:2]]};
        endcase
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule

// *** pwmh_props.sv ***
// Purpose: Port checker for the PWM block
// Assumes: One clock, synchronous active-low reset
// Notes: Bus timing as handed over by the designer
`timescale 1ns/10ps
module pwmh_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic trip_pin,
  input wire logic [4:0] pwm_out,
  input wire logic trip_irq
);
  logic aw_bad;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Outside the window, or the hole at 0xac
  function automatic logic bad(input logic [31:0] a);
    return a[31:6] != 26'h3fffc3e || a[5:0] == 6'h2c;
  endfunction
  // Held from address phase, since bresp comes later
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) aw_bad <= bad(s_axi_awaddr);
  end
  rst_state_a:
  assert property ($rose(aresetn) |-> pwm_out == 5'h05 && !trip_irq)
    else $error("bad state after reset");
  aw_block_a:
  assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  ar_block_a:
  assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  r_answer_a:
  assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  b_answer_a:
  assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  b_resp_a:
  assert property ($rose(s_axi_bvalid) |-> s_axi_bresp ==
    (aw_bad ? pwmh_pkg::RESP_SLVERR : pwmh_pkg::RESP_OKAY))
    else $error("wrong write response");
  r_resp_a:
  assert property (s_axi_arvalid && s_axi_arready && bad(s_axi_araddr)
    |=> s_axi_rresp == pwmh_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  irq_rise_a:
  assert property ($rose(trip_irq) |-> !$past(trip_pin, 3))
    else $error("trip flag without trip level");
  irq_clear_a:
  assert property ($fell(trip_irq) |-> s_axi_bvalid)
    else $error("trip flag dropped without a write");
endmodule
bind pwmh_top pwmh_props u_props (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .trip_pin, .pwm_out, .trip_irq);

// *** pwmh_stage.sv ***
// Purpose: Power stage stand-in driving the trip and sync pins
// Assumes: Both pins pulled up on the board
// Notes: A fault shows only when the bench commands it
`timescale 1ns/10ps
module pwmh_stage (
  input wire logic aclk,
  input wire logic fault,
  input wire logic sync_req,
  output logic trip_pin,
  output logic sync_pin
);
  // Released lines float to the pull-up level
  initial trip_pin = 1'b1;
  initial sync_pin = 1'b1;
  always @(posedge aclk) begin
    trip_pin <= !fault;
    sync_pin <= !sync_req;
  end
endmodule

// *** pwmh_tb_top.sv ***
// Purpose: Register-driven bench for the PWM block
// Assumes: 40 MHz aclk, bready and rready held high
// Notes: Waveforms judged by high-time counts per window
`timescale 1ns/10ps
module pwmh_tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, trip_irq, trip_pin, sync_pin;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [31:0] s_axi_rdata, rv;
  logic [4:0] pwm_out;
  logic fault = 1'b0, sync_req = 1'b0;
  int err_total = 0, comparisons = 0;
  logic [15:0] cfg [11] = '{16'h8402, 16'h8806, 16'h8c01, 16'h9009,
    16'h9401, 16'h9803, 16'h9c00, 16'ha004, 16'ha400, 16'ha805, 16'hb009};
  // Control, then high ticks of out4..out0 per 100 ticks
  logic [55:0] hb [6] = '{56'h0003_3264646464, 56'h0203_3214280000,
    56'h0207_3200001428, 56'h0223_3264641428, 56'h0227_3214286464,
    56'h0213_3200640064};
  always #12.5 aclk = ~aclk;
  pwmh_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trip_pin, .sync_pin,
    .pwm_out, .trip_irq);
  pwmh_stage u_stage (.aclk, .fault, .sync_req, .trip_pin, .sync_pin);
  task automatic close_out;
    $display("Compared %0d, mismatched %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic [4:0] got, input logic [4:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t pins=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  function automatic logic [31:0] ad(input logic [7:0] o);
    return {24'hffff0f, o};
  endfunction
  task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
    int k;
    k = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      k++;
    end while (!s_axi_bvalid && k < 50);
    if (!s_axi_bvalid) begin
      err_total++;
      close_out();
    end
    chk_val({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [31:0] a);
    int k;
    k = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      k++;
    end while (!s_axi_rvalid && k < 50);
    if (!s_axi_rvalid) begin
      err_total++;
      close_out();
    end
    rv = s_axi_rdata;
    rr = s_axi_rresp;
  endtask
  task automatic rdc(input logic [31:0] a, exp, input logic [1:0] er);
    rd(a);
    chk_val(rv, exp);
    chk_val({30'h0, rr}, {30'h0, er});
  endtask
  // One pair0 period of settling first: a new divider starts mid-period
  task automatic meas(input logic [15:0] c, input logic [39:0] e);
    int n[5];
    int w;
    int i;
    w = 200 << c[8:6];
    n = '{default: 0};
    wr(ad(8'h80), {16'h0, c}, 2'b00);
    tick(w / 10);
    repeat (w) begin
      @(posedge aclk);
      for (i = 0; i < 5; i++) if (pwm_out[i] === 1'b1) n[i]++;
    end
    for (i = 0; i < 5; i++) chk_val(n[i], e[8*i +: 8] * (2 << c[8:6]));
  endtask
  initial begin
    int i;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_pin(pwm_out, 5'h05);
    rdc(ad(8'h80), 32'h0012, 2'b00);
    wr(ad(8'h80), 32'hdfff, 2'b00);
    rdc(ad(8'h80), 32'h5fff, 2'b00);
    wr(32'h0000_0080, 32'h1, 2'b10);
    rdc(ad(8'hac), 32'h0, 2'b10);
    for (i = 0; i < 11; i++) begin
      rdc(ad(cfg[i][15:8]), 32'h0, 2'b00);
      wr(ad(cfg[i][15:8]), {24'h0, cfg[i][7:0]}, 2'b00);
      rdc(ad(cfg[i][15:8]), {24'h0, cfg[i][7:0]}, 2'b00);
    end
    for (i = 0; i < 8; i++) meas(16'h0001 | 16'(i << 6), 40'h3214281428);
    meas(16'h1801, 40'h3250285028);
    meas(16'h0000, 40'h0);
    for (i = 0; i < 6; i++) meas(hb[i][55:40], hb[i][39:0]);
    wr(ad(8'h80), 32'h0401, 2'b00);
    fault <= 1'b1;
    tick(8);
    chk_pin({4'h0, trip_irq}, 5'h01);
    rdc(ad(8'h80), 32'h0400, 2'b00);
    rdc(ad(8'hbc), 32'h1, 2'b00);
    fault <= 1'b0;
    tick(6);
    chk_pin({4'h0, trip_irq}, 5'h01);
    wr(ad(8'hb8), 32'h0, 2'b00);
    chk_pin({4'h0, trip_irq}, 5'h00);
    rdc(ad(8'hb8), 32'h0, 2'b00);
    wr(ad(8'h80), 32'h0001, 2'b00);
    fault <= 1'b1;
    tick(8);
    chk_pin({4'h0, trip_irq}, 5'h00);
    rdc(ad(8'h80), 32'h0001, 2'b00);
    fault <= 1'b0;
    wr(ad(8'h90), 32'h0fff, 2'b00);
    tick(600);
    sync_req <= 1'b1;
    tick(8);
    rd(ad(8'hb4));
    chk_val({31'h0, rv >= 32'd200}, 32'h1);
    sync_req <= 1'b0;
    wr(ad(8'h80), 32'h4001, 2'b00);
    tick(600);
    sync_req <= 1'b1;
    tick(6);
    rd(ad(8'hb4));
    chk_val({31'h0, rv < 32'd16}, 32'h1);
    // Byte strobes: each lane lands alone, the other byte keeps its value
    s_axi_wstrb <= 4'h2;
    wr(ad(8'h84), 32'h5a77, 2'b00);
    rdc(ad(8'h84), 32'h5a02, 2'b00);
    s_axi_wstrb <= 4'h1;
    wr(ad(8'h84), 32'h3c11, 2'b00);
    rdc(ad(8'h84), 32'h5a11, 2'b00);
    close_out();
  end
endmodule
